/* File: hdl/current_limit_lock_fault_handler.sv */
module current_limit_lock_fault_handler
  import lock_fault_pkg::*;
#(
  parameter logic [15:0] RETRY_WAIT_US = lock_fault_pkg::RETRY_WAIT_US_RST
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // avalon-mm slave
  input  wire logic [11:0] address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [3:0]  byteenable_in,
  input  wire logic [31:0] writedata_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  // comparator pin
  input  wire logic        current_limit_trip_in,
  // driver and fault outputs
  output logic             fault_n_out,
  output logic             gate_hiz_out,
  output logic             low_side_brake_out,
  output logic             irq_out
);
  import lock_fault_pkg::*;

  localparam logic [9:0] FILTER_STEP = 10'(FILTER_STEP_CYCLES);
  localparam logic [6:0] US_LAST     = 7'(US_CYCLES - 1);

  logic [31:0]            config_two;
  logic [EV_W-1:0]        status;
  logic [EV_W-1:0]        mask;
  logic [15:0]            lock_retry_wait;
  logic                   ack;
  logic                   trip_meta;
  logic                   trip_sync;
  logic [9:0]             filt_cnt;
  logic                   lock_filtered;
  logic                   lock_filtered_d;
  logic [6:0]             us_div;
  logic                   us_tick;
  logic [15:0]            wait_cnt;
  logic [COUNT_W-1:0]     retry_count;
  logic                   fault_brake;
  fault_state_type        state;
  fault_state_type        next_state;
  logic [COUNT_W-1:0]     next_retry_count;
  logic [3:0]             action;
  logic [2:0]             filter_code;
  logic [2:0]             limit_code;
  logic [COUNT_W-1:0]     limit_attempts;
  logic [9:0]             filt_target;
  logic                   detect_enabled;
  logic                   report_mode;
  logic                   retry_mode;
  logic                   wait_done;
  logic                   bus_write;
  logic [9:0]             word_idx;
  logic                   addr_ok;
  logic                   clear_cmd;
  logic [EV_W-1:0]        events;
  logic [31:0]            state_word;

  assign action         = config_two[ACTION_LSB +: ACTION_W];
  assign filter_code    = config_two[FILTER_LSB +: FILTER_W];
  assign limit_code     = config_two[RETRY_LIMIT_LSB +: RETRY_LIMIT_W];
  assign limit_attempts = retry_attempts(limit_code);
  assign detect_enabled = action <= ACTION_REPORT;
  assign report_mode    = action == ACTION_REPORT;
  assign retry_mode     = action[3:2] == 2'b01;
  assign filt_target    = 10'(filter_code * FILTER_STEP);

  // ---------------- bus slave: one wait state on every access ----------------
  assign word_idx        = address_in[11:2];
  assign addr_ok         = address_in[1:0] == 2'b00;
  assign waitrequest_out = (read_in | write_in) & ~ack;
  assign bus_write       = write_in & ack & addr_ok;
  assign clear_cmd       = bus_write & (word_idx == STATE_IDX) & byteenable_in[0]
                           & writedata_in[ST_ACTIVE];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ack <= 1'b0;
    end else begin
      ack <= (read_in | write_in) & ~ack;
    end
  end

  assign state_word = {23'h0, retry_count, gate_hiz_out, low_side_brake_out,
                       state == FAULT_LATCHED, state != FAULT_IDLE};

  // read data loaded at the edge that raises ack, so it stands while waitrequest is low
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      readdata_out <= 32'h0000_0000;
    end else if (read_in & ~ack) begin
      readdata_out <= 32'h0000_0000;
      if (addr_ok) begin
        unique case (word_idx)
          CONFIG_TWO_IDX: readdata_out <= config_two;
          STATUS_IDX:     readdata_out <= {29'h0, status};
          MASK_IDX:       readdata_out <= {29'h0, mask};
          RETRY_WAIT_IDX: readdata_out <= {16'h0, lock_retry_wait};
          STATE_IDX:      readdata_out <= state_word;
          default:        readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      config_two      <= CONFIG_TWO_RST;
      mask            <= '0;
      lock_retry_wait <= RETRY_WAIT_US;
    end else if (bus_write) begin
      if (word_idx == CONFIG_TWO_IDX) begin
        config_two <= merge(config_two, writedata_in, byteenable_in);
      end
      if (word_idx == MASK_IDX && byteenable_in[0]) begin
        mask <= writedata_in[EV_W-1:0];
      end
      if (word_idx == RETRY_WAIT_IDX) begin
        if (byteenable_in[0]) begin
          lock_retry_wait[7:0] <= writedata_in[7:0];
        end
        if (byteenable_in[1]) begin
          lock_retry_wait[15:8] <= writedata_in[15:8];
        end
      end
    end
  end

  // sticky events: a new event in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      status <= '0;
    end else begin
      status <= (status & ~((bus_write && word_idx == STATUS_IDX && byteenable_in[0])
                            ? writedata_in[EV_W-1:0] : '0)) | events;
    end
  end

  assign irq_out = |(status & mask);

  // ---------------- trip input: synchroniser and filter ----------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      trip_meta <= 1'b0;
      trip_sync <= 1'b0;
    end else begin
      trip_meta <= current_limit_trip_in;
      trip_sync <= trip_meta;
    end
  end

  // counts cycles rather than us ticks so the filter time is exact, not off by a partial tick
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      filt_cnt      <= '0;
      lock_filtered <= 1'b0;
    end else if (!trip_sync || !detect_enabled) begin
      filt_cnt      <= '0;
      lock_filtered <= 1'b0;
    end else if (filt_cnt >= filt_target) begin
      lock_filtered <= 1'b1;
    end else begin
      filt_cnt <= filt_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      lock_filtered_d <= 1'b0;
    end else begin
      lock_filtered_d <= lock_filtered;
    end
  end

  // ---------------- microsecond enable and retry wait ----------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      us_div <= '0;
    end else begin
      us_div <= (us_div == US_LAST) ? 7'h00 : us_div + 7'h01;
    end
  end

  assign us_tick   = us_div == US_LAST;
  assign wait_done = state == FAULT_RETRY && wait_cnt >= lock_retry_wait;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || state != FAULT_RETRY) begin
      wait_cnt <= '0;
    end else if (us_tick && !wait_done) begin
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end

  // ---------------- fault state machine ----------------
  always_comb begin
    next_state       = state;
    next_retry_count = retry_count;
    unique case (state)
      FAULT_IDLE: begin
        if (lock_filtered && !report_mode && detect_enabled) begin
          if (retry_mode) begin
            next_retry_count = (retry_count == '1) ? retry_count : retry_count + 5'h01;
            if (limit_attempts != '0 && next_retry_count > limit_attempts) begin
              next_state = FAULT_LATCHED;
            end else begin
              next_state = FAULT_RETRY;
            end
          end else begin
            next_state = FAULT_LATCHED;
          end
        end
      end
      FAULT_RETRY: begin
        if (wait_done) begin
          next_state = FAULT_IDLE;
        end
      end
      FAULT_LATCHED: begin
        next_state = FAULT_LATCHED;
      end
    endcase
    if (clear_cmd) begin
      next_state       = FAULT_IDLE;
      next_retry_count = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state       <= FAULT_IDLE;
      retry_count <= '0;
    end else begin
      state       <= next_state;
      retry_count <= next_retry_count;
    end
  end

  // gate reaction frozen at fault entry so a config write cannot flip a live bridge
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fault_brake <= 1'b0;
    end else if (state == FAULT_IDLE && next_state != FAULT_IDLE) begin
      fault_brake <= action[1];
    end
  end

  assign events[EV_LOCK]    = lock_filtered & ~lock_filtered_d;
  assign events[EV_LATCHED] = state != FAULT_LATCHED && next_state == FAULT_LATCHED;
  assign events[EV_CLEARED] = state == FAULT_RETRY && next_state == FAULT_IDLE && !clear_cmd;

  assign gate_hiz_out       = state != FAULT_IDLE && !fault_brake;
  assign low_side_brake_out = state != FAULT_IDLE && fault_brake;
  assign fault_n_out        = !(state != FAULT_IDLE || (report_mode && lock_filtered));

  // ---------------- checks ----------------
  filter_time_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(lock_filtered) |-> $past(filt_cnt) == $past(filt_target) && $past(trip_sync))
    else $error("lock declared before the filter time elapsed");

  filter_zero_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    trip_sync && detect_enabled && filter_code == 3'h0 && !lock_filtered |=> lock_filtered)
    else $error("unfiltered trip not declared next cycle");

  latch_hiz_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == FAULT_IDLE && lock_filtered && action[3:1] == 3'b000 && !clear_cmd
    |=> state == FAULT_LATCHED && gate_hiz_out && !fault_n_out && !low_side_brake_out)
    else $error("latched tristate fault not taken");

  latch_brake_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == FAULT_IDLE && lock_filtered && action[3:1] == 3'b001 && !clear_cmd
    |=> state == FAULT_LATCHED && low_side_brake_out && !fault_n_out && !gate_hiz_out)
    else $error("latched brake fault not taken");

  retry_hiz_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == FAULT_IDLE && lock_filtered && action[3:1] == 3'b010 && !clear_cmd
    && (limit_attempts == '0 || retry_count < limit_attempts)
    |=> state == FAULT_RETRY && gate_hiz_out && !low_side_brake_out && !fault_n_out)
    else $error("retry fault not entered with tristate");

  retry_brake_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == FAULT_IDLE && lock_filtered && action[3:1] == 3'b011 && !clear_cmd
    && (limit_attempts == '0 || retry_count < limit_attempts)
    |=> state == FAULT_RETRY && low_side_brake_out && !gate_hiz_out && !fault_n_out)
    else $error("retry fault not entered with brake");

  auto_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == FAULT_RETRY && wait_cnt >= lock_retry_wait |=> state == FAULT_IDLE)
    else $error("fault not cleared after retry wait");

  retry_limit_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == FAULT_IDLE && lock_filtered && retry_mode && limit_attempts != '0
    && retry_count >= limit_attempts && !clear_cmd |=> state == FAULT_LATCHED)
    else $error("retry limit exceeded without latching");

  report_only_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == FAULT_IDLE && report_mode |=> state == FAULT_IDLE)
    else $error("report only mode changed the bridge");

  disabled_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    action >= ACTION_DISABLED |=> !lock_filtered)
    else $error("lock seen while detection disabled");

  disabled_quiet_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    action >= ACTION_DISABLED && state == FAULT_IDLE && !clear_cmd
    |=> state == FAULT_IDLE && fault_n_out)
    else $error("disabled detection still raised a fault");

  filter_restart_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !trip_sync |=> filt_cnt == 10'h000 && !lock_filtered)
    else $error("filter not restarted when trip dropped");

  report_pins_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    report_mode && lock_filtered && state == FAULT_IDLE
    |-> !fault_n_out && !gate_hiz_out && !low_side_brake_out)
    else $error("report only lock not shown on fault pin");

  lock_event_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(lock_filtered) |=> status[EV_LOCK])
    else $error("lock event not recorded in status");
endmodule : current_limit_lock_fault_handler

/* File: hdl/lock_fault_pkg.sv */
package lock_fault_pkg;
  // clock and time base
  localparam int          CLK_MHZ            = 125;
  localparam int          FILTER_STEP_US     = 1;
  localparam int          FILTER_STEP_CYCLES = FILTER_STEP_US * CLK_MHZ;
  localparam int          US_CYCLES          = CLK_MHZ;
  localparam logic [15:0] RETRY_WAIT_US_RST  = 16'h03e8;

  // register word indices; byte address is four times the index
  localparam logic [9:0]  CONFIG_TWO_IDX   = 10'h092;
  localparam logic [9:0]  STATUS_IDX       = 10'h093;
  localparam logic [9:0]  MASK_IDX         = 10'h094;
  localparam logic [9:0]  RETRY_WAIT_IDX   = 10'h095;
  localparam logic [9:0]  STATE_IDX        = 10'h096;
  localparam logic [31:0] CONFIG_TWO_RST   = 32'h0000_0000;

  // fault_config_two fields
  localparam int ACTION_LSB      = 15;
  localparam int ACTION_W        = 4;
  localparam int FILTER_LSB      = 12;
  localparam int FILTER_W        = 3;
  localparam int RETRY_LIMIT_LSB = 0;
  localparam int RETRY_LIMIT_W   = 3;

  // action codes
  localparam logic [3:0] ACTION_REPORT   = 4'h8;
  localparam logic [3:0] ACTION_DISABLED = 4'h9;

  // status and mask bits
  localparam int EV_LOCK    = 0;
  localparam int EV_LATCHED = 1;
  localparam int EV_CLEARED = 2;
  localparam int EV_W       = 3;

  // state register fields
  localparam int ST_ACTIVE    = 0;
  localparam int ST_LATCHED   = 1;
  localparam int ST_BRAKE     = 2;
  localparam int ST_HIZ       = 3;
  localparam int ST_COUNT_LSB = 4;
  localparam int COUNT_W      = 5;

  typedef enum logic [1:0] {FAULT_IDLE, FAULT_RETRY, FAULT_LATCHED} fault_state_type;

  // attempts allowed per retry limit code, 0 meaning no limit
  function automatic logic [COUNT_W-1:0] retry_attempts(input logic [2:0] code);
    logic [COUNT_W-1:0] n;
    n = 5'h00;
    case (code)
      3'h1: n = 5'h02;
      3'h2: n = 5'h03;
      3'h3: n = 5'h05;
      3'h4: n = 5'h07;
      3'h5: n = 5'h0a;
      3'h6: n = 5'h0f;
      3'h7: n = 5'h14;
      default: n = 5'h00;
    endcase
    return n;
  endfunction : retry_attempts
endpackage : lock_fault_pkg

/* File: tb/bridge_model.sv */
module bridge_model (
  // gate commands from the handler
  input  wire logic       gate_hiz_in,
  input  wire logic       low_side_brake_in,
  // bridge condition: 0 driven, 1 floating, 2 braking, 3 both at once
  output logic      [1:0] phase_state_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // a conflict shows as 3 so the bench never mistakes it for a legal state
  always_comb begin
    phase_state_out = {low_side_brake_in, gate_hiz_in};
  end
endmodule : bridge_model

/* File: tb/current_limit_lock_fault_handler_tb.sv */
module current_limit_lock_fault_handler_tb
  import lock_fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        reset_n;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        trip;
  logic        fault_n;
  logic        gate_hiz;
  logic        brake;
  logic        irq;
  logic [1:0]  phase_state;
  logic [31:0] q;
  logic [3:0]  a;
  logic [2:0]  c;
  int          err_count;
  int          tests_run;

  current_limit_lock_fault_handler #(.RETRY_WAIT_US(16'h0002)) u_current_limit_lock_fault_handler (
    .clk_in(clk), .reset_n_in(reset_n), .address_in(address), .read_in(read),
    .write_in(write), .byteenable_in(byteenable), .writedata_in(writedata),
    .readdata_out(readdata), .waitrequest_out(waitrequest), .current_limit_trip_in(trip),
    .fault_n_out(fault_n), .gate_hiz_out(gate_hiz), .low_side_brake_out(brake), .irq_out(irq));
  bridge_model u_bridge_model (
    .gate_hiz_in(gate_hiz), .low_side_brake_in(brake), .phase_state_out(phase_state));

  always #4 clk = ~clk;

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected register at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_reg

  // packs fault_n, bridge condition and irq so one compare sees the whole reaction
  task automatic chk_pins(input logic [3:0] exp);
    logic [3:0] got;
    got = {fault_n, phase_state, irq};
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected pins at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_pins

  // one idle edge first, so a release and the next request never share a time step
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] d,
                     output logic [31:0] rdata);
    @(posedge clk);
    address   <= {idx, 2'b00};
    write     <= wr;
    read      <= ~wr;
    writedata <= d;
    // held until an edge sees waitrequest low; the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rdata = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, idx, d, dummy);
  endtask : wr

  task automatic hold(input int cycles);
    @(posedge clk);
    trip <= 1'b1;
    repeat (cycles) @(posedge clk);
    trip <= 1'b0;
  endtask : hold

  function automatic logic [31:0] cfg(input logic [3:0] act, input logic [2:0] flt,
                                      input logic [2:0] lim);
    return {13'h0000, act, flt, 9'h000, lim};
  endfunction : cfg

  function automatic logic [3:0] exp_pins(input logic [3:0] act, input logic on,
                                          input logic irq_e);
    if (!on) return {1'b1, 2'b00, irq_e};
    if (act == ACTION_REPORT) return {1'b0, 2'b00, irq_e};
    return {1'b0, act[1], ~act[1], irq_e};
  endfunction : exp_pins

  function automatic int tries(input logic [2:0] code);
    int t[8] = '{0, 2, 3, 5, 7, 10, 15, 20};
    return t[code];
  endfunction : tries

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 12'h000;
    byteenable = 4'hf;
    writedata = 32'h0000_0000;
    trip = 1'b0;
    err_count = 0;
    tests_run = 0;
    void'($urandom(86451));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b0, CONFIG_TWO_IDX, 32'h0, q);
    chk_reg(q, CONFIG_TWO_RST);
    bus(1'b0, RETRY_WAIT_IDX, 32'h0, q);
    chk_reg(q, 32'h0000_0002);
    bus(1'b0, 10'h3ff, 32'h0, q);
    chk_reg(q, 32'h0000_0000);
    wr(MASK_IDX, 32'h0000_0001);
    // every action code, one trip each, unfiltered
    for (int i = 0; i < 16; i++) begin
      a = 4'(i);
      wr(CONFIG_TWO_IDX, cfg(a, 3'h0, 3'($urandom_range(0, 7))));
      hold(8);
      chk_pins(exp_pins(a, a < 4'h9, a < 4'h9));
      repeat (8) @(posedge clk);
      chk_pins(exp_pins(a, a < 4'h8, a < 4'h9));
      if (a >= 4'h4 && a <= 4'h7) begin
        repeat (300) @(posedge clk);
        chk_pins(exp_pins(a, 1'b0, 1'b1));
      end
      bus(1'b0, STATUS_IDX, 32'h0, q);
      chk_reg(q & 32'h1, {31'h0, a < 4'h9});
      wr(STATUS_IDX, 32'h0000_0007);
      wr(STATE_IDX, 32'h0000_0001);
      @(posedge clk);
      chk_pins(4'b1000);
    end
    // filter: two short pulses with a one-cycle gap must not add up
    c = 3'($urandom_range(1, 7));
    wr(CONFIG_TWO_IDX, cfg(4'h0, c, 3'h0));
    hold(int'(c) * 125 - 6);
    hold(int'(c) * 125 - 6);
    repeat (8) @(posedge clk);
    chk_pins(4'b1000);
    hold(int'(c) * 125 + 12);
    chk_pins(exp_pins(4'h0, 1'b1, 1'b1));
    wr(STATUS_IDX, 32'h0000_0007);
    wr(STATE_IDX, 32'h0000_0001);
    // retry limit: the lock after the last allowed attempt latches
    c = 3'($urandom_range(1, 3));
    a = 4'h4 | 4'($urandom_range(0, 3));
    wr(CONFIG_TWO_IDX, cfg(a, 3'h0, c));
    for (int k = 1; k <= tries(c) + 1; k++) begin
      hold(8);
      repeat (300) @(posedge clk);
      chk_pins(exp_pins(a, k > tries(c), 1'b1));
    end
    bus(1'b0, STATE_IDX, 32'h0, q);
    chk_reg(q, {23'h0, 5'(tries(c) + 1), ~a[1], a[1], 2'b11});
    bus(1'b0, STATUS_IDX, 32'h0, q);
    chk_reg(q, 32'h0000_0007);
    wr(STATUS_IDX, 32'h0000_0007);
    wr(STATE_IDX, 32'h0000_0001);
    @(posedge clk);
    chk_pins(4'b1000);
    // mid-run reset drops a live brake fault and the configuration
    wr(CONFIG_TWO_IDX, cfg(4'h2, 3'h0, 3'h0));
    hold(8);
    chk_pins(exp_pins(4'h2, 1'b1, 1'b1));
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    chk_pins(4'b1000);
    bus(1'b0, CONFIG_TWO_IDX, 32'h0, q);
    chk_reg(q, CONFIG_TWO_RST);
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule : current_limit_lock_fault_handler_tb
